/* sdg_pkg.sv */
// constants shared by the self-diagnostic sequencer and its helpers
// assumes a 125 MHz system clock and a 32-bit classic Wishbone register port
package sdg_pkg;

  // register byte offsets
  localparam logic [7:0] SDG_ADR_CTRL = 8'h00;
  localparam logic [7:0] SDG_ADR_STAT = 8'h04;
  localparam logic [7:0] SDG_ADR_IRQ_STAT = 8'h08;
  localparam logic [7:0] SDG_ADR_IRQ_MASK = 8'h0C;

  // control register fields
  localparam int SDG_CTRL_START_BIT = 0;
  localparam int SDG_CTRL_EXT_BIT = 1;
  localparam int SDG_CTRL_LED_CLR_BIT = 2;
  localparam logic SDG_CTRL_EXT_RST = 1'b0;

  // status register fields
  localparam int SDG_STAT_BUSY_BIT = 0;
  localparam int SDG_STAT_FAIL_BIT = 1;
  localparam int SDG_STAT_KIND_LSB = 2;
  localparam int SDG_STAT_OFFLINE_BIT = 4;
  localparam int SDG_STAT_LED_BIT = 5;
  localparam int SDG_STAT_STRAP_BIT = 8;

  // interrupt status and mask fields
  localparam int SDG_IRQ_W = 2;
  localparam int SDG_IRQ_DONE_BIT = 0;
  localparam int SDG_IRQ_FAIL_BIT = 1;
  localparam logic [SDG_IRQ_W-1:0] SDG_IRQ_MASK_RST = 2'h0;

  // test kinds driven to the test engines
  localparam logic [1:0] SDG_KIND_HW = 2'h0;
  localparam logic [1:0] SDG_KIND_SEEK = 2'h1;
  localparam logic [1:0] SDG_KIND_WR = 2'h2;

  // hardware items: program memory, processor peripherals, working ram, data buffer
  localparam logic [1:0] SDG_HW_PROG = 2'h0;
  localparam logic [1:0] SDG_HW_LAST = 2'h3;
  // seek modes: two-point, one-position sequential
  localparam logic [1:0] SDG_SEEK_TWO_POINT = 2'h0;
  localparam logic [1:0] SDG_SEEK_LAST = 2'h1;
  // write/read patterns, first then second
  localparam logic [1:0] SDG_WR_FIRST = 2'h0;
  localparam logic [1:0] SDG_WR_LAST = 2'h1;
  localparam logic [47:0] SDG_PAT_A = 48'hBBBA645A27BB;
  localparam logic [47:0] SDG_PAT_B = 48'h000000000000;

  // identifier field is read from this track after every seek
  localparam logic [3:0] SDG_ID_TRACK = 4'h0;

  // led blink timing
  localparam int unsigned SDG_CLK_HZ = 125000000;
  localparam int unsigned SDG_LED_HALF_MS = 250;
  localparam int unsigned SDG_LED_HALF_CYC = (SDG_CLK_HZ / 1000) * SDG_LED_HALF_MS;

  // sequencer states
  typedef enum logic [2:0] {
    SDG_S_IDLE,
    SDG_S_DRAIN,
    SDG_S_LAUNCH,
    SDG_S_RUN,
    SDG_S_STEP,
    SDG_S_FINISH,
    SDG_S_HALT
  } sdg_state_t;

  // what started the current run
  typedef enum logic [1:0] {
    SDG_M_POWER,
    SDG_M_OFFLINE,
    SDG_M_ONLINE,
    SDG_M_SOFT
  } sdg_mode_t;

endpackage : sdg_pkg

/* sdg_sync.sv */
// two-flop synchroniser for levels arriving from pins
// assumes the inputs are slow levels with no timing relation to sys_clk_i
module sdg_sync
  import sdg_pkg::*;
#(
  parameter int W = 1
)
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // one pair of flops per bit; the first flop feeds only the second
  for (genvar i = 0; i < W; i++)
  begin : g_bit
    always_ff @(posedge sys_clk_i)
    begin
      if (!rst_n_i)
      begin
        meta_q[i] <= 1'b0;
        sync_q[i] <= 1'b0;
      end
      else
      begin
        meta_q[i] <= async_i[i];
        sync_q[i] <= meta_q[i];
      end
    end
  end

  assign sync_o = sync_q;

endmodule : sdg_sync

/* sdg_led_blink.sv */
// front-panel led blinker
// assumes en_i is a level on sys_clk_i; led is dark while en_i is low
module sdg_led_blink
  import sdg_pkg::*;
#(
  parameter int unsigned HALF_CYC = SDG_LED_HALF_CYC
)
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  output logic led_o
);

  logic [31:0] cnt_q;
  logic led_q;
  wire logic wrap;

  assign wrap = (cnt_q == 32'(HALF_CYC - 1));

  // half-period counter toggles the lamp while enabled
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i || !en_i)
    begin
      cnt_q <= 32'h00000000;
      led_q <= 1'b0;
    end
    else if (wrap)
    begin
      cnt_q <= 32'h00000000;
      led_q <= ~led_q;
    end
    else
    begin
      cnt_q <= cnt_q + 32'h00000001;
    end
  end

  assign led_o = led_q;

endmodule : sdg_led_blink

/* sdg_diag_seq.sv */
// self-diagnostic sequencer of the drive unit with its register port
// assumes test engines on sys_clk_i, a scsi command decoder on sys_clk_i,
// the strap on an asynchronous pin, and a classic Wishbone master
module sdg_diag_seq
  import sdg_pkg::*;
#(
  parameter int CW = 16,
  parameter logic [15:0] CYL_MAX = 16'h07FF,
  parameter int unsigned LED_HALF_CYC = SDG_LED_HALF_CYC
)
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  // strap pin, high while the contact is open
  input wire logic diagnostic_strap_i,
  // scsi side
  input wire logic scsi_busy_i,
  input wire logic diag_cmd_valid_i,
  input wire logic diag_selftest_i,
  input wire logic diag_extended_i,
  output logic diag_status_valid_o,
  output logic diag_status_check_o,
  output logic scsi_ignore_o,
  // test engines
  output logic test_req_o,
  output logic [1:0] test_kind_o,
  output logic [1:0] test_item_o,
  output logic [47:0] test_pattern_o,
  output logic [CW-1:0] test_cyl_o,
  output logic [3:0] test_track_o,
  input wire logic test_done_i,
  input wire logic test_fail_i,
  input wire logic [CW-1:0] test_id_cyl_i,
  output logic led_o
);

  sdg_state_t state_q, state_d;
  sdg_mode_t mode_q, mode_d;
  logic ext_q, ext_d;
  logic [1:0] kind_q, kind_d;
  logic [1:0] item_q, item_d;
  logic [47:0] pat_q, pat_d;
  logic [CW-1:0] cyl_q, cyl_d;
  logic req_q, req_d;
  logic bad_q, bad_d;
  logic [1:0] bad_kind_q, bad_kind_d;
  logic blink_q;
  logic st_valid_q;
  logic st_check_q;
  logic ignore_q;
  logic ctrl_ext_q;
  logic soft_pend_q;
  logic [SDG_IRQ_W-1:0] irq_stat_q;
  logic [SDG_IRQ_W-1:0] irq_mask_q;
  logic irq_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic strap_s;

  // strap pin passes two flops before any logic sees it
  sdg_sync #(
    .W(1)
  ) u_strap_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(diagnostic_strap_i),
    .sync_o(strap_s)
  );

  // bus decode; a write lands on the edge at which the master sees ack
  wire logic bus_req = wb_cyc_i && wb_stb_i && !ack_q;
  wire logic bus_wr = wb_cyc_i && wb_stb_i && ack_q && wb_we_i && wb_sel_i[0];
  wire logic sel_ctrl = (wb_adr_i == SDG_ADR_CTRL);
  wire logic sel_stat = (wb_adr_i == SDG_ADR_STAT);
  wire logic sel_istat = (wb_adr_i == SDG_ADR_IRQ_STAT);
  wire logic sel_imask = (wb_adr_i == SDG_ADR_IRQ_MASK);
  wire logic wr_ctrl = bus_wr && sel_ctrl;
  wire logic wr_istat = bus_wr && sel_istat;
  wire logic wr_imask = bus_wr && sel_imask;
  wire logic soft_set = wr_ctrl && wb_dat_i[SDG_CTRL_START_BIT];
  wire logic led_clr = wr_ctrl && wb_dat_i[SDG_CTRL_LED_CLR_BIT];

  // sequencer decisions
  wire logic idle = (state_q == SDG_S_IDLE);
  wire logic take_offline = idle && strap_s;
  wire logic take_cmd = idle && !strap_s && diag_cmd_valid_i;
  wire logic take_soft = idle && !strap_s && !diag_cmd_valid_i && soft_pend_q;
  wire logic seek_miss = (kind_q == SDG_KIND_SEEK) && (test_id_cyl_i != cyl_q);
  wire logic test_bad = test_fail_i || seek_miss;
  wire logic hw_end = (kind_q == SDG_KIND_HW) && (item_q == SDG_HW_LAST);
  wire logic seek_end = (kind_q == SDG_KIND_SEEK) && (item_q == SDG_SEEK_LAST);
  wire logic wr_end = (kind_q == SDG_KIND_WR) && (item_q == SDG_WR_LAST);
  wire logic full_set = (mode_q == SDG_M_OFFLINE) || ext_q;
  wire logic loop_on = (mode_q == SDG_M_OFFLINE) && strap_s;
  wire logic seq_end = (hw_end && !full_set) || (wr_end && !loop_on);
  wire logic finish = (state_q == SDG_S_FINISH);
  wire logic scsi_src = (mode_q == SDG_M_ONLINE);

  // next seek target: two-point alternates ends, sequential steps by one
  wire logic [CW-1:0] two_point = (cyl_q == CW'(0)) ? CW'(CYL_MAX) : CW'(0);
  wire logic [CW-1:0] seq_next = (cyl_q >= CW'(CYL_MAX)) ? CW'(0) : cyl_q + CW'(1);

  // sequencer next state
  always_comb
  begin
    state_d = state_q;
    mode_d = mode_q;
    ext_d = ext_q;
    kind_d = kind_q;
    item_d = item_q;
    pat_d = pat_q;
    cyl_d = cyl_q;
    req_d = req_q;
    bad_d = bad_q;
    bad_kind_d = bad_kind_q;
    case (state_q)
      SDG_S_IDLE:
      begin
        kind_d = SDG_KIND_HW;
        item_d = SDG_HW_PROG;
        if (take_offline)
        begin
          mode_d = SDG_M_OFFLINE;
          state_d = SDG_S_DRAIN;
        end
        else if (take_cmd)
        begin
          mode_d = SDG_M_ONLINE;
          ext_d = diag_extended_i;
          // without the diagnose request no test runs and good comes at once
          state_d = diag_selftest_i ? SDG_S_LAUNCH : SDG_S_FINISH;
          bad_d = 1'b0;
        end
        else if (take_soft)
        begin
          mode_d = SDG_M_SOFT;
          ext_d = ctrl_ext_q;
          state_d = SDG_S_LAUNCH;
        end
      end
      SDG_S_DRAIN:
      begin
        // wait for executing and stacked commands to end
        if (!strap_s)
        begin
          state_d = SDG_S_IDLE;
        end
        else if (!scsi_busy_i)
        begin
          state_d = SDG_S_LAUNCH;
        end
      end
      SDG_S_LAUNCH:
      begin
        req_d = 1'b1;
        bad_d = 1'b0;
        state_d = SDG_S_RUN;
      end
      SDG_S_RUN:
      begin
        if (test_done_i)
        begin
          req_d = 1'b0;
          if (test_bad)
          begin
            bad_d = 1'b1;
            bad_kind_d = kind_q;
            state_d = SDG_S_FINISH;
          end
          else
          begin
            state_d = SDG_S_STEP;
          end
        end
      end
      SDG_S_STEP:
      begin
        state_d = SDG_S_LAUNCH;
        if (seq_end)
        begin
          state_d = SDG_S_FINISH;
        end
        else if (hw_end)
        begin
          kind_d = SDG_KIND_SEEK;
          item_d = SDG_SEEK_TWO_POINT;
          cyl_d = two_point;
        end
        else if (seek_end)
        begin
          kind_d = SDG_KIND_WR;
          item_d = SDG_WR_FIRST;
          pat_d = SDG_PAT_A;
        end
        else if (wr_end)
        begin
          kind_d = SDG_KIND_HW;
          item_d = SDG_HW_PROG;
        end
        else
        begin
          item_d = item_q + 2'h1;
          if (kind_q == SDG_KIND_SEEK)
          begin
            cyl_d = seq_next;
          end
          if (kind_q == SDG_KIND_WR)
          begin
            pat_d = SDG_PAT_B;
          end
        end
      end
      SDG_S_FINISH:
      begin
        state_d = (bad_q && mode_q == SDG_M_OFFLINE) ? SDG_S_HALT : SDG_S_IDLE;
      end
      SDG_S_HALT:
      begin
        // an offline error stops the loop until the strap is closed
        if (!strap_s)
        begin
          state_d = SDG_S_IDLE;
        end
      end
      default:
      begin
        state_d = SDG_S_IDLE;
      end
    endcase
  end

  // sequencer registers; reset launches the power-up hardware test
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= SDG_S_LAUNCH;
      mode_q <= SDG_M_POWER;
      ext_q <= 1'b0;
      kind_q <= SDG_KIND_HW;
      item_q <= SDG_HW_PROG;
      pat_q <= SDG_PAT_A;
      cyl_q <= CW'(0);
      req_q <= 1'b0;
      bad_q <= 1'b0;
      bad_kind_q <= SDG_KIND_HW;
    end
    else
    begin
      state_q <= state_d;
      mode_q <= mode_d;
      ext_q <= ext_d;
      kind_q <= kind_d;
      item_q <= item_d;
      pat_q <= pat_d;
      cyl_q <= cyl_d;
      req_q <= req_d;
      bad_q <= bad_d;
      bad_kind_q <= bad_kind_d;
    end
  end

  // command status, bus silence and led enable
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      st_valid_q <= 1'b0;
      st_check_q <= 1'b0;
      ignore_q <= 1'b0;
      blink_q <= 1'b0;
    end
    else
    begin
      st_valid_q <= finish && scsi_src;
      st_check_q <= finish && scsi_src && bad_q;
      ignore_q <= strap_s || (mode_q == SDG_M_OFFLINE && !idle);
      if (finish && bad_q && bad_kind_q == SDG_KIND_HW)
      begin
        blink_q <= 1'b1;
      end
      else if (led_clr)
      begin
        blink_q <= 1'b0;
      end
    end
  end

  // control register and pending software start; a new start wins over take
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_ext_q <= SDG_CTRL_EXT_RST;
      soft_pend_q <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        ctrl_ext_q <= wb_dat_i[SDG_CTRL_EXT_BIT];
      end
      soft_pend_q <= soft_set || (soft_pend_q && !take_soft);
    end
  end

  // interrupt events; a set in the clearing cycle survives
  wire logic [SDG_IRQ_W-1:0] irq_ev = {finish && bad_q, finish && !bad_q};
  wire logic [SDG_IRQ_W-1:0] irq_w1c = wr_istat ? wb_dat_i[SDG_IRQ_W-1:0] : 2'h0;

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      irq_stat_q <= 2'h0;
      irq_mask_q <= SDG_IRQ_MASK_RST;
      irq_q <= 1'b0;
    end
    else
    begin
      irq_stat_q <= (irq_stat_q & ~irq_w1c) | irq_ev;
      if (wr_imask)
      begin
        irq_mask_q <= wb_dat_i[SDG_IRQ_W-1:0];
      end
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  // read multiplexer; unmapped offsets read zero
  wire logic [31:0] stat_word = {23'h000000, strap_s, 2'h0, blink_q,
    (mode_q == SDG_M_OFFLINE), bad_kind_q, bad_q, !idle};
  wire logic [31:0] rd_mux =
    sel_ctrl ? {30'h00000000, ctrl_ext_q, 1'b0} :
    sel_stat ? stat_word :
    sel_istat ? {30'h00000000, irq_stat_q} :
    sel_imask ? {30'h00000000, irq_mask_q} : 32'h00000000;

  // one-cycle ack one edge after the request
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
    end
    else
    begin
      ack_q <= bus_req;
      if (bus_req)
      begin
        rdat_q <= rd_mux;
      end
    end
  end

  // front-panel lamp
  sdg_led_blink #(
    .HALF_CYC(LED_HALF_CYC)
  ) u_led (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .en_i(blink_q),
    .led_o(led_o)
  );

  assign wb_dat_o = rdat_q;
  assign wb_ack_o = ack_q;
  assign irq_o = irq_q;
  assign diag_status_valid_o = st_valid_q;
  assign diag_status_check_o = st_check_q;
  assign scsi_ignore_o = ignore_q;
  assign test_req_o = req_q;
  assign test_kind_o = kind_q;
  assign test_item_o = item_q;
  assign test_pattern_o = pat_q;
  assign test_cyl_o = cyl_q;
  assign test_track_o = SDG_ID_TRACK;

endmodule : sdg_diag_seq

/* sdg_diag_seq_assertions.sv */
// concurrent checks on the ports of the self-diagnostic sequencer
// assumes one clock domain and the synchronous active-low reset
module sdg_diag_seq_checker
  import sdg_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic diagnostic_strap_i,
  input wire logic scsi_busy_i,
  input wire logic scsi_ignore_o,
  input wire logic diag_status_valid_o,
  input wire logic diag_status_check_o,
  input wire logic test_req_o,
  input wire logic [1:0] test_kind_o,
  input wire logic [1:0] test_item_o,
  input wire logic [47:0] test_pattern_o,
  input wire logic [3:0] test_track_o,
  input wire logic test_done_i
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  // power-up launches the hardware test at once
  chk_powerup_launch: assert property ($rose(rst_n_i) |=> test_req_o && test_kind_o == SDG_KIND_HW)
    else $error("power-up run did not start with the hardware test");
  chk_req_holds: assert property (test_req_o && !test_done_i |=> test_req_o)
    else $error("test request dropped before done");
  chk_done_drops: assert property (test_req_o && test_done_i |=> !test_req_o)
    else $error("test request still high after done");
  chk_seek_track: assert property (test_req_o && test_kind_o == SDG_KIND_SEEK |-> test_track_o == SDG_ID_TRACK)
    else $error("seek identifier read from wrong track");
  chk_wr_pattern: assert property (test_req_o && test_kind_o == SDG_KIND_WR |->
    test_pattern_o == ((test_item_o == SDG_WR_FIRST) ? SDG_PAT_A : SDG_PAT_B))
    else $error("write/read pattern wrong for item");
  chk_strap_ignore: assert property ($rose(diagnostic_strap_i) |-> ##[1:4] scsi_ignore_o)
    else $error("open strap did not enter offline mode");
  chk_ignore_quiet: assert property (scsi_ignore_o |-> !diag_status_valid_o)
    else $error("status posted while offline");
  chk_drain_wait: assert property (scsi_ignore_o && scsi_busy_i |-> !test_req_o)
    else $error("offline test started with scsi work pending");
  chk_check_cause: assert property (diag_status_valid_o && diag_status_check_o |-> $past(test_done_i, 2))
    else $error("check condition without a finished test");
  chk_good_clean: assert property (diag_status_valid_o && !diag_status_check_o |-> !$past(test_done_i, 1))
    else $error("good status one cycle after a test answer");
  chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus access not acknowledged next cycle");

  cov_check: cover property (diag_status_valid_o && diag_status_check_o);
  cov_offline_run: cover property (scsi_ignore_o && test_req_o);
  cov_second_pattern: cover property (test_req_o && test_kind_o == SDG_KIND_WR && test_item_o == SDG_WR_LAST);
endmodule : sdg_diag_seq_checker

bind sdg_diag_seq sdg_diag_seq_checker sdg_diag_seq_checker_i (.sys_clk_i(sys_clk_i),
  .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .diagnostic_strap_i(diagnostic_strap_i), .scsi_busy_i(scsi_busy_i),
  .scsi_ignore_o(scsi_ignore_o), .diag_status_valid_o(diag_status_valid_o),
  .diag_status_check_o(diag_status_check_o), .test_req_o(test_req_o),
  .test_kind_o(test_kind_o), .test_item_o(test_item_o), .test_pattern_o(test_pattern_o),
  .test_track_o(test_track_o), .test_done_i(test_done_i));

/* sdg_far_model.sv */
// far-side model: scsi host issuing diagnostic commands, plus the test engines
// assumes the design clock; the bench sets slow, bad_id and fail_at between runs
module sdg_far_model
  import sdg_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic test_req_i,
  input wire logic [1:0] test_kind_i,
  input wire logic [1:0] test_item_i,
  input wire logic [15:0] test_cyl_i,
  output logic test_done_o,
  output logic test_fail_o,
  output logic [15:0] test_id_cyl_o,
  output logic diag_cmd_valid_o,
  output logic diag_selftest_o,
  output logic diag_extended_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic slow = 1'b0;
  logic bad_id = 1'b0;
  logic [3:0] fail_at = 4'hF; // kind and item that fails; F never matches
  logic [3:0] log_q[$];
  logic act = 1'b0;
  int cnt = 0;

  initial
  begin
    test_done_o = 1'b0;
    test_fail_o = 1'b0;
    test_id_cyl_o = 16'h0000;
    diag_cmd_valid_o = 1'b0;
    diag_selftest_o = 1'b0;
    diag_extended_o = 1'b0;
  end

  // engine: take a request, log it, answer after a prompt or slow delay
  always @(posedge sys_clk_i)
  begin
    test_done_o <= 1'b0;
    test_fail_o <= ~test_fail_o;
    test_id_cyl_o <= ~test_id_cyl_o;
    if (!rst_n_i)
      act <= 1'b0;
    else if (test_req_i && !act && !test_done_o)
    begin
      act <= 1'b1;
      cnt <= slow ? 6 : 1;
      log_q.push_back({test_kind_i, test_item_i});
    end
    else if (act && cnt > 1)
      cnt <= cnt - 1;
    else if (act)
    begin
      act <= 1'b0;
      test_done_o <= 1'b1;
      test_fail_o <= ({test_kind_i, test_item_i} == fail_at);
      test_id_cyl_o <= (bad_id && test_kind_i == SDG_KIND_SEEK) ? ~test_cyl_i : test_cyl_i;
    end
  end

  // host: one decoded diagnostic command pulse with its two flags
  task automatic send_diag(input logic st, input logic ext);
    @(posedge sys_clk_i);
    diag_cmd_valid_o <= 1'b1;
    diag_selftest_o <= st;
    diag_extended_o <= ext;
    @(posedge sys_clk_i);
    diag_cmd_valid_o <= 1'b0;
    diag_selftest_o <= ~st;
    diag_extended_o <= ~ext;
  endtask : send_diag
endmodule : sdg_far_model

/* testbench.sv */
// self-checking bench for the self-diagnostic sequencer
// assumes sdg_far_model as host and test engines; led half period shortened to 4
module testbench
  import sdg_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, irq_o, scsi_ignore_o, led_o, test_req_o, test_done_i, test_fail_i;
  logic diagnostic_strap_i = 1'b0, scsi_busy_i = 1'b0;
  logic diag_cmd_valid_i, diag_selftest_i, diag_extended_i;
  logic diag_status_valid_o, diag_status_check_o;
  logic [1:0] test_kind_o, test_item_o;
  logic [47:0] test_pattern_o;
  logic [15:0] test_cyl_o, test_id_cyl_i;
  logic [3:0] test_track_o;
  int miscompares = 0, total_checks = 0, status_seen = 0;

  always #4 sys_clk_i = ~sys_clk_i;

  sdg_diag_seq #(.LED_HALF_CYC(4)) sdg_diag_seq_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .irq_o(irq_o), .diagnostic_strap_i(diagnostic_strap_i), .scsi_busy_i(scsi_busy_i),
    .diag_cmd_valid_i(diag_cmd_valid_i), .diag_selftest_i(diag_selftest_i),
    .diag_extended_i(diag_extended_i), .diag_status_valid_o(diag_status_valid_o),
    .diag_status_check_o(diag_status_check_o), .scsi_ignore_o(scsi_ignore_o),
    .test_req_o(test_req_o), .test_kind_o(test_kind_o), .test_item_o(test_item_o),
    .test_pattern_o(test_pattern_o), .test_cyl_o(test_cyl_o), .test_track_o(test_track_o),
    .test_done_i(test_done_i), .test_fail_i(test_fail_i), .test_id_cyl_i(test_id_cyl_i),
    .led_o(led_o));

  sdg_far_model sdg_far_model_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .test_req_i(test_req_o), .test_kind_i(test_kind_o), .test_item_i(test_item_o),
    .test_cyl_i(test_cyl_o), .test_done_o(test_done_i), .test_fail_o(test_fail_i),
    .test_id_cyl_o(test_id_cyl_i), .diag_cmd_valid_o(diag_cmd_valid_i),
    .diag_selftest_o(diag_selftest_i), .diag_extended_o(diag_extended_i));

  // count every status pulse the design posts
  always @(posedge sys_clk_i)
    if (diag_status_valid_o === 1'b1)
      status_seen++;

  task automatic summarize();
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one classic bus cycle, held until ack
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    @(posedge sys_clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
    n = 0;
    do
    begin
      @(posedge sys_clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1)
      chk("wb_ack", 32'h1, 32'(wb_ack_o));
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask : wb

  task automatic wait_idle();
    logic [31:0] q;
    int n;
    n = 0;
    do
    begin
      wb(1'b0, SDG_ADR_STAT, 32'h0, q);
      n++;
    end
    while (q[SDG_STAT_BUSY_BIT] !== 1'b0 && n < 400);
    chk("idle", 32'h0, 32'(q[SDG_STAT_BUSY_BIT]));
  endtask : wait_idle

  function automatic logic [3:0] exp_step(input int i);
    if (i < 4)
      return {SDG_KIND_HW, 2'(i)};
    if (i < 6)
      return {SDG_KIND_SEEK, 2'(i - 4)};
    return {SDG_KIND_WR, 2'(i - 6)};
  endfunction : exp_step

  task automatic chk_log(input int n);
    chk("log_size", 32'(n), 32'(sdg_far_model_i.log_q.size()));
    for (int i = 0; i < n && i < sdg_far_model_i.log_q.size(); i++)
      chk("log_step", 32'(exp_step(i % 8)), 32'(sdg_far_model_i.log_q[i]));
  endtask : chk_log

  task automatic led_seen(input int n, output logic seen);
    seen = 1'b0;
    repeat (n) @(posedge sys_clk_i) seen |= (led_o === 1'b1);
  endtask : led_seen

  task automatic t_powerup();
    logic [31:0] q;
    wait_idle();
    chk_log(4);
    wb(1'b0, SDG_ADR_IRQ_MASK, 32'h0, q);
    chk("irq_mask", 32'h0, q);
    wb(1'b0, 8'h40, 32'h0, q);
    chk("unmapped", 32'h0, q);
    chk("track", 32'h0, 32'(test_track_o));
    sdg_far_model_i.log_q.delete();
    wb(1'b1, SDG_ADR_CTRL, 32'h1, q);
    wait_idle();
    chk_log(4);
    chk("soft_no_status", 32'h0, 32'(status_seen));
    chk("led", 32'h0, 32'(led_o));
  endtask : t_powerup

  task automatic t_online(input logic ext, input logic exp_ck, input int n);
    int w;
    wait_idle();
    sdg_far_model_i.log_q.delete();
    sdg_far_model_i.send_diag(1'b1, ext);
    w = 0;
    while (diag_status_valid_o !== 1'b1 && w < 3000)
    begin
      @(posedge sys_clk_i);
      w++;
    end
    chk("status_valid", 32'h1, 32'(diag_status_valid_o));
    chk("status_check", 32'(exp_ck), 32'(diag_status_check_o));
    chk_log(n);
  endtask : t_online

  task automatic t_irq();
    logic [31:0] q;
    wb(1'b0, SDG_ADR_IRQ_STAT, 32'h0, q);
    chk("irq_stat", 32'h3, q);
    chk("irq_masked", 32'h0, 32'(irq_o));
    wb(1'b1, SDG_ADR_IRQ_MASK, 32'h2, q);
    repeat (2) @(posedge sys_clk_i);
    chk("irq_on", 32'h1, 32'(irq_o));
    wb(1'b1, SDG_ADR_IRQ_STAT, 32'h3, q);
    repeat (2) @(posedge sys_clk_i);
    chk("irq_clr", 32'h0, 32'(irq_o));
  endtask : t_irq

  task automatic t_hwfail();
    logic seen;
    logic [31:0] q;
    sdg_far_model_i.fail_at = {SDG_KIND_HW, 2'h2};
    t_online(1'b1, 1'b1, 3);
    led_seen(20, seen);
    chk("led_blink", 32'h1, 32'(seen));
    wb(1'b1, SDG_ADR_CTRL, 32'h4, q);
    sdg_far_model_i.fail_at = {SDG_KIND_HW, 2'h0};
    sdg_far_model_i.log_q.delete();
    rst_n_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    wait_idle();
    chk_log(1);
    led_seen(20, seen);
    chk("led_powerup", 32'h1, 32'(seen));
    wb(1'b1, SDG_ADR_CTRL, 32'h4, q);
    // the lamp lags the blink enable by one edge
    @(posedge sys_clk_i);
    led_seen(20, seen);
    chk("led_cleared", 32'h0, 32'(seen));
    sdg_far_model_i.fail_at = 4'hF;
  endtask : t_hwfail

  task automatic t_offline();
    int w, st;
    sdg_far_model_i.log_q.delete();
    scsi_busy_i <= 1'b1;
    diagnostic_strap_i <= 1'b1;
    repeat (20) @(posedge sys_clk_i);
    chk("drain", 32'h0, 32'(sdg_far_model_i.log_q.size()));
    chk("ignore_on", 32'h1, 32'(scsi_ignore_o));
    st = status_seen;
    sdg_far_model_i.send_diag(1'b1, 1'b0);
    scsi_busy_i <= 1'b0;
    w = 0;
    while (sdg_far_model_i.log_q.size() < 9 && w < 3000)
    begin
      @(posedge sys_clk_i);
      w++;
    end
    diagnostic_strap_i <= 1'b0;
    wait_idle();
    chk_log(16);
    chk("no_status", 32'(st), 32'(status_seen));
    chk("ignore_off", 32'h0, 32'(scsi_ignore_o));
  endtask : t_offline

  initial
  begin
    #(8 * 60000);
    miscompares++;
    $display("MISMATCH watchdog expected finish seen hang");
    summarize();
  end

  initial
  begin
    repeat (4) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    t_powerup();
    t_online(1'b0, 1'b0, 4);
    sdg_far_model_i.slow = 1'b1;
    t_online(1'b1, 1'b0, 8);
    sdg_far_model_i.bad_id = 1'b1;
    t_online(1'b1, 1'b1, 5);
    chk("led_seek_fail", 32'h0, 32'(led_o));
    sdg_far_model_i.bad_id = 1'b0;
    t_irq();
    t_hwfail();
    t_offline();
    summarize();
  end
endmodule : testbench
